// *** logic/ecfi_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module ecfi_top
	import ecfi_pkg::*;
#(
	parameter int DATA_WIDTH      = 32,
	parameter bit ECC_EN          = 1'b1,
	parameter bit FAULT_INJECT_EN = 1'b1,
	parameter bit UPPER_CAPTURE   = 1'b0,
	localparam int CHK_W          = ecfi_check_width(DATA_WIDTH)
) (
	input  wire logic                  core_clk,
	input  wire logic                  nrst,
	input  wire logic                  ce,
	input  wire logic                  ctrl_wr,
	input  wire logic                  ctrl_rd,
	input  wire logic [ADDR_W-1:0]     ctrl_addr,
	input  wire logic [WORD_W-1:0]     ctrl_wdata,
	output logic      [WORD_W-1:0]     ctrl_rdata,
	output logic                       ctrl_rvalid,
	input  wire logic                  ue_event,
	input  wire logic [DATA_WIDTH-1:0] ue_data,
	input  wire logic                  mem_wr_valid,
	input  wire logic [DATA_WIDTH-1:0] mem_wr_data,
	input  wire logic [CHK_W-1:0]      mem_wr_check,
	output logic                       mem_out_valid,
	output logic      [DATA_WIDTH-1:0] mem_out_data,
	output logic      [CHK_W-1:0]      mem_out_check,
	output logic                       uncorrectable_error_flag
);
	localparam int DWORDS  = DATA_WIDTH / WORD_W;
	localparam bit FI_ON   = FAULT_INJECT_EN && ECC_EN;

	if (DATA_WIDTH != DW_32 && DATA_WIDTH != DW_64 && DATA_WIDTH != DW_128) begin : g_bad_dw
		$error("Data width must be 32, 64 or 128");
	end

	if (DWORDS > N_WORDS || CHK_W > WORD_W) begin : g_bad_words
		$error("Data width exceeds the register words");
	end

	logic rst_n;

	ecfi_rst_sync u_rst_sync (
		.core_clk   (core_clk),
		.nrst       (nrst),
		.rst_n_sync (rst_n)
	);

	// Status flag and capture arming
	ecfi_cap_t cap_state_q;
	ecfi_cap_t cap_state_d;
	logic      clr_ue;
	logic      capture;

	assign clr_ue = ctrl_wr && ctrl_addr == OFS_STATUS && ctrl_wdata[UE_FLAG_BIT];

	always_comb begin
		capture     = 1'b0;
		cap_state_d = cap_state_q;
		case (cap_state_q)
			CAP_ARMED: begin
				if (ue_event) begin
					capture     = 1'b1;
					cap_state_d = CAP_HELD;
				end
			end
			CAP_HELD: begin
				if (clr_ue) begin
					// New error in the clearing cycle wins
					capture     = ue_event;
					cap_state_d = ue_event ? CAP_HELD : CAP_ARMED;
				end
			end
			default: begin
				cap_state_d = CAP_ARMED;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_state_q <= CAP_ARMED;
		end else if (ce) begin
			cap_state_q <= cap_state_d;
		end
	end

	assign uncorrectable_error_flag = cap_state_q == CAP_HELD;

	// Set by the first capture, for the zero-until-capture check
	logic captured_q;
	logic captured_d;

	always_comb begin
		captured_d = captured_q | capture;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			captured_q <= 1'b0;
		end else if (ce) begin
			captured_q <= captured_d;
		end
	end

	// Per-word capture and data injection registers
	logic [WORD_W-1:0]     cap_q [N_WORDS];
	logic [WORD_W-1:0]     fi_q  [N_WORDS];
	logic [WORD_W-1:0]     cap_rd[N_WORDS];
	logic [DATA_WIDTH-1:0] fi_vec;

	for (genvar w = 0; w < N_WORDS; w++) begin : g_word
		localparam logic [ADDR_W-1:0] UE_ADR = OFS_UE_DATA0 + WORD_STRIDE * ADDR_W'(w);
		localparam logic [ADDR_W-1:0] FI_ADR = OFS_FI_DATA0 + WORD_STRIDE * ADDR_W'(w);
		// Word 0 capture unused; upper words held back this release
		localparam bit CAP_ON = ECC_EN && w >= 1 && w < DWORDS && (w == 1 || UPPER_CAPTURE);
		localparam bit FIW_ON = FI_ON && w < DWORDS;
		logic [WORD_W-1:0] cap_d;
		logic [WORD_W-1:0] fi_d;

		always_comb begin
			cap_d = cap_q[w];
			if (CAP_ON && capture) begin
				cap_d = ue_data[w*WORD_W +: WORD_W];
			end
		end

		always_comb begin
			fi_d = fi_q[w];
			if (FIW_ON && mem_wr_valid) begin
				fi_d = RESET_WORD;
			end
			if (FIW_ON && ctrl_wr && ctrl_addr == FI_ADR) begin
				fi_d = ctrl_wdata;
			end
		end

		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				cap_q[w] <= RESET_WORD;
				fi_q[w]  <= RESET_WORD;
			end else if (ce) begin
				cap_q[w] <= cap_d;
				fi_q[w]  <= fi_d;
			end
		end

		assign cap_rd[w] = ctrl_addr == UE_ADR ? cap_q[w] : RESET_WORD;

		if (w < DWORDS) begin : g_fi
			assign fi_vec[w*WORD_W +: WORD_W] = fi_q[w];
		end
	end

	// Check-bit injection register
	logic [CHK_W-1:0] fi_chk_q;
	logic [CHK_W-1:0] fi_chk_d;

	always_comb begin
		fi_chk_d = fi_chk_q;
		if (FI_ON && mem_wr_valid) begin
			fi_chk_d = '0;
		end
		if (FI_ON && ctrl_wr && ctrl_addr == OFS_FI_CHECK) begin
			fi_chk_d = ctrl_wdata[CHK_W-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fi_chk_q <= '0;
		end else if (ce) begin
			fi_chk_q <= fi_chk_d;
		end
	end

	// Write path: check bits come from clean data upstream
	logic                  out_valid_d;
	logic [DATA_WIDTH-1:0] out_data_d;
	logic [CHK_W-1:0]      out_check_d;

	always_comb begin
		out_valid_d = mem_wr_valid;
		out_data_d  = mem_out_data;
		out_check_d = mem_out_check;
		if (mem_wr_valid) begin
			out_data_d  = mem_wr_data ^ fi_vec;
			out_check_d = mem_wr_check ^ fi_chk_q;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_out_valid <= 1'b0;
			mem_out_data  <= '0;
			mem_out_check <= '0;
		end else if (ce) begin
			mem_out_valid <= out_valid_d;
			mem_out_data  <= out_data_d;
			mem_out_check <= out_check_d;
		end
	end

	// Register read port
	logic [WORD_W-1:0] rdata_d;
	logic [WORD_W-1:0] rdata_hold_d;
	logic              rvalid_d;

	always_comb begin
		rdata_d = RESET_WORD;
		if (ctrl_addr == OFS_STATUS) begin
			rdata_d[UE_FLAG_BIT] = uncorrectable_error_flag;
		end
		for (int i = 0; i < N_WORDS; i++) begin
			rdata_d = rdata_d | cap_rd[i];
		end
		// Read data stands until the next read
		rdata_hold_d = ctrl_rd ? rdata_d : ctrl_rdata;
		rvalid_d     = ctrl_rd;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_rdata  <= RESET_WORD;
			ctrl_rvalid <= 1'b0;
		end else if (ce) begin
			ctrl_rdata  <= rdata_hold_d;
			ctrl_rvalid <= rvalid_d;
		end
	end

	// Checks
	AST_FLAG_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
		ce && ue_event |=> uncorrectable_error_flag)
		else $error("flag not set after error");

	AST_FLAG_KEEP: assert property (@(posedge core_clk) disable iff (!rst_n)
		uncorrectable_error_flag && !(ce && clr_ue) |=> uncorrectable_error_flag)
		else $error("flag dropped without clear");

	AST_FLAG_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
		ce && clr_ue && !ue_event |=> !uncorrectable_error_flag)
		else $error("flag not cleared by write of one");

	AST_ZERO_UNTIL_CAPTURE: assert property (@(posedge core_clk) disable iff (!rst_n)
		!captured_q |-> !uncorrectable_error_flag && cap_q[1] == RESET_WORD
		&& cap_q[2] == RESET_WORD && cap_q[3] == RESET_WORD)
		else $error("capture word nonzero before any error");

	AST_HOLD_WORD: assert property (@(posedge core_clk) disable iff (!rst_n)
		uncorrectable_error_flag && !clr_ue |=> $stable(cap_q[1]))
		else $error("captured word changed while held");

	if (DWORDS > 1 && ECC_EN) begin : g_ast_cap
		AST_CAPTURE: assert property (@(posedge core_clk) disable iff (!rst_n)
			ce && ue_event && !uncorrectable_error_flag
			|=> cap_q[1] == $past(ue_data[2*WORD_W-1:WORD_W]))
			else $error("upper data word not captured");

		AST_REARM: assert property (@(posedge core_clk) disable iff (!rst_n)
			ce && ue_event && clr_ue |=> uncorrectable_error_flag
			&& cap_q[1] == $past(ue_data[2*WORD_W-1:WORD_W]))
			else $error("error in clearing cycle not captured");

		AST_WORD1_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
			ce && ctrl_rd && ctrl_addr == OFS_UE_DATA0 + WORD_STRIDE
			|=> ctrl_rdata == $past(cap_q[1]))
			else $error("captured word read wrong");
	end

	if (!UPPER_CAPTURE) begin : g_ast_upper
		AST_UPPER_UNUSED: assert property (@(posedge core_clk) disable iff (!rst_n)
			ce && ctrl_rd && ctrl_addr[ADDR_W-1:4] == OFS_UE_DATA0[ADDR_W-1:4] && ctrl_addr[3]
			|=> ctrl_rdata == RESET_WORD)
			else $error("unused upper capture word read not zero");
	end

	if (FI_ON) begin : g_ast_fi
		AST_FI_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
			ce && ctrl_wr && ctrl_addr == OFS_FI_DATA0 |=> fi_q[0] == $past(ctrl_wdata))
			else $error("data injection word not loaded");

		AST_CHK_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
			ce && ctrl_wr && ctrl_addr == OFS_FI_CHECK
			|=> fi_chk_q == $past(ctrl_wdata[CHK_W-1:0]))
			else $error("check injection field not loaded");
	end else begin : g_ast_nofi
		AST_FI_ABSENT: assert property (@(posedge core_clk) disable iff (!rst_n)
			fi_vec == '0 && fi_chk_q == '0)
			else $error("injection active without both options");
	end

	AST_DATA_FLIP: assert property (@(posedge core_clk) disable iff (!rst_n)
		ce && mem_wr_valid |=> mem_out_valid && mem_out_data == $past(mem_wr_data ^ fi_vec))
		else $error("data injection not applied");

	AST_CHECK_FLIP: assert property (@(posedge core_clk) disable iff (!rst_n)
		ce && mem_wr_valid |=> mem_out_check == $past(mem_wr_check ^ fi_chk_q))
		else $error("check injection not applied");

	AST_SELF_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
		ce && mem_wr_valid && !ctrl_wr ##1 !ctrl_wr [*2] |-> fi_vec == '0 && fi_chk_q == '0)
		else $error("injection not cleared after write");

	AST_FI_READ_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
		ce && ctrl_rd && ctrl_addr >= OFS_FI_DATA0 |=> ctrl_rvalid && ctrl_rdata == RESET_WORD)
		else $error("injection register read not zero");

	AST_WORD0_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
		ce && ctrl_rd && ctrl_addr == OFS_UE_DATA0 |=> ctrl_rdata == RESET_WORD)
		else $error("unused word read not zero");

	AST_STATUS_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
		ce && ctrl_rd && ctrl_addr == OFS_STATUS
		|=> ctrl_rdata == {{(WORD_W-1){1'b0}}, $past(uncorrectable_error_flag)})
		else $error("status read wrong");

	AST_RVALID_PULSE: assert property (@(posedge core_clk) disable iff (!rst_n)
		ce |=> ctrl_rvalid == $past(ctrl_rd))
		else $error("read valid not one cycle after read");

	AST_MISALIGNED_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
		ce && ctrl_rd && ctrl_addr[1:0] != 2'h0 |=> ctrl_rdata == RESET_WORD)
		else $error("reserved location read not zero");

	AST_VALID_DROP: assert property (@(posedge core_clk) disable iff (!rst_n)
		ce && !mem_wr_valid |=> !mem_out_valid)
		else $error("memory write valid without a write");
endmodule : ecfi_top
`default_nettype wire

// *** pkg/ecfi_pkg.sv ***
`default_nettype none
package ecfi_pkg;
	localparam int          ADDR_W        = 12;
	localparam int          WORD_W        = 32;
	localparam int          N_WORDS       = 4;
	localparam int          UE_FLAG_BIT   = 0;
	localparam int          DW_32         = 32;
	localparam int          DW_64         = 64;
	localparam int          DW_128        = 128;
	localparam int          CHK_W_32      = 7;
	localparam int          CHK_W_64      = 8;
	localparam int          CHK_W_128     = 9;
	localparam logic [11:0] OFS_STATUS    = 12'h000;
	localparam logic [11:0] OFS_UE_DATA0  = 12'h200;
	localparam logic [11:0] OFS_FI_DATA0  = 12'h300;
	localparam logic [11:0] OFS_FI_CHECK  = 12'h380;
	localparam logic [11:0] WORD_STRIDE   = 12'h004;
	localparam logic [31:0] RESET_WORD    = 32'h0000_0000;

	typedef enum logic [1:0] {
		CAP_ARMED = 2'b01,
		CAP_HELD  = 2'b10
	} ecfi_cap_t;

	function automatic int ecfi_check_width(input int dw);
		if (dw == DW_32) begin
			return CHK_W_32;
		end else if (dw == DW_64) begin
			return CHK_W_64;
		end
		return CHK_W_128;
	endfunction : ecfi_check_width
endpackage : ecfi_pkg
`default_nettype wire

// *** logic/ecfi_rst_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module ecfi_rst_sync (
	input  wire logic core_clk,
	input  wire logic nrst,
	output logic      rst_n_sync
);
	logic [1:0] sync_q;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sync_q <= 2'b00;
		end else begin
			sync_q <= {sync_q[0], 1'b1};
		end
	end

	assign rst_n_sync = sync_q[1];
endmodule : ecfi_rst_sync
`default_nettype wire

// *** sim/ecfi_wr_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module ecfi_wr_model (
	input  wire logic        core_clk,
	input  wire logic        go,
	input  wire logic [63:0] wdata,
	output logic             mem_wr_valid,
	output logic      [63:0] mem_wr_data,
	output logic      [7:0]  mem_wr_check
);
	initial begin
		mem_wr_valid = 1'b0;
		mem_wr_data  = 64'h0;
		mem_wr_check = 8'h0;
	end
	// One write per request; idle lines toggle
	always @(posedge core_clk) begin
		mem_wr_valid <= go;
		mem_wr_data  <= go ? wdata : ~mem_wr_data;
		mem_wr_check <= go ? wdata[7:0] ^ wdata[15:8] : ~mem_wr_check;
	end
endmodule : ecfi_wr_model
`default_nettype wire

// *** sim/ecc_error_capture_fault_inject_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module ecc_error_capture_fault_inject_tb;
	import ecfi_pkg::*;
	logic        core_clk, nrst, ctrl_wr, ctrl_rd, ue_event, go, fl;
	logic        ctrl_rvalid, mem_wr_valid, mem_out_valid, ue_flag, ce;
	logic [11:0] ctrl_addr;
	logic [31:0] ctrl_wdata, ctrl_rdata, w0, w1, c;
	logic [31:0] rs = 32'h0000_1278;
	logic [63:0] ue_data, wdata, mem_wr_data, mem_out_data, cap;
	logic [7:0]  mem_wr_check, mem_out_check;
	logic [11:0] za [12] = '{12'h000, 12'h200, 12'h204, 12'h208, 12'h20C, 12'h280,
		12'h2C0, 12'h300, 12'h304, 12'h380, 12'h3F0, 12'h1C0};
	int          bad_count = 0;
	int          check_count = 0;
	ecfi_top #(.DATA_WIDTH(64)) u_ecfi_top (.core_clk(core_clk), .nrst(nrst), .ce(ce),
		.ctrl_wr(ctrl_wr), .ctrl_rd(ctrl_rd), .ctrl_addr(ctrl_addr),
		.ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata), .ctrl_rvalid(ctrl_rvalid),
		.ue_event(ue_event), .ue_data(ue_data), .mem_wr_valid(mem_wr_valid),
		.mem_wr_data(mem_wr_data), .mem_wr_check(mem_wr_check),
		.mem_out_valid(mem_out_valid), .mem_out_data(mem_out_data),
		.mem_out_check(mem_out_check), .uncorrectable_error_flag(ue_flag));
	ecfi_wr_model u_ecfi_wr_model (.core_clk(core_clk), .go(go), .wdata(wdata),
		.mem_wr_valid(mem_wr_valid), .mem_wr_data(mem_wr_data),
		.mem_wr_check(mem_wr_check));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : xs
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge core_clk);
		ctrl_wr    <= 1'b1;
		ctrl_addr  <= a;
		ctrl_wdata <= v;
		@(posedge core_clk);
		ctrl_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge core_clk);
		ctrl_rd   <= 1'b1;
		ctrl_addr <= a;
		@(posedge core_clk);
		ctrl_rd <= 1'b0;
		#1;
		chk(ctrl_rvalid, 1'b1);
		chk(ctrl_rdata, e);
	endtask : rd
	task automatic mw(input logic [63:0] v, input logic [7:0] ci);
		@(posedge core_clk);
		go    <= 1'b1;
		wdata <= v;
		@(posedge core_clk);
		go <= 1'b0;
		@(posedge core_clk);
		#1;
		chk(mem_out_valid, 1'b1);
		chk(mem_out_data, v ^ {w1, w0});
		chk(mem_out_check, v[7:0] ^ v[15:8] ^ ci);
		w0 = '0;
		w1 = '0;
	endtask : mw
	task automatic ue(input logic [63:0] v);
		@(posedge core_clk);
		ue_event <= 1'b1;
		ue_data  <= v;
		@(posedge core_clk);
		ue_event <= 1'b0;
		ue_data  <= ~v;
		if (!fl) cap = v;
		fl = 1'b1;
		#1;
		chk(ue_flag, 1'b1);
	endtask : ue
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results
	initial begin
		#100000;
		bad_count++;
		results();
	end
	initial begin
		{nrst, ctrl_wr, ctrl_rd, ue_event, go, fl} = '0;
		{ctrl_addr, ctrl_wdata, ue_data, wdata, w0, w1, cap} = '0;
		ce = 1'b1;
		repeat (6) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge core_clk);
		foreach (za[i]) rd(za[i], 32'h0);
		for (int k = 0; k < 4; k++) begin
			w0 = xs();
			w1 = xs();
			c  = xs();
			wr(OFS_FI_DATA0, w0);
			wr(12'h304, w1);
			wr(12'h308, xs());
			wr(OFS_FI_CHECK, c);
			mw({xs(), xs()}, c[7:0]);
			rd(OFS_FI_DATA0, 32'h0);
			mw({xs(), xs()}, 8'h00);
		end
		c  = xs();
		w1 = 32'h1 << c[4:0];
		wr(12'h304, w1);
		mw({xs(), xs()}, 8'h00);
		ue({xs(), xs()});
		rd(12'h204, cap[63:32]);
		rd(12'h205, 32'h0);
		ue({xs(), xs()});
		rd(12'h204, cap[63:32]);
		wr(OFS_STATUS, 32'h0);
		rd(OFS_STATUS, 32'h1);
		wr(OFS_STATUS, 32'h1);
		fl = 1'b0;
		rd(OFS_STATUS, 32'h0);
		@(posedge core_clk);
		ce       <= 1'b0;
		ue_event <= 1'b1;
		ue_data  <= {xs(), xs()};
		@(posedge core_clk);
		ue_event <= 1'b0;
		@(posedge core_clk);
		ce <= 1'b1;
		#1;
		chk(ue_flag, 1'b0);
		rd(12'h204, cap[63:32]);
		ue({xs(), xs()});
		rd(12'h204, cap[63:32]);
		rd(12'h208, 32'h0);
		results();
	end
endmodule : ecc_error_capture_fault_inject_tb
`default_nettype wire
